// >>> logic/spwm_top.sv
module spwm_top
  import spwm_pkg::*;
(
  input  wire logic                   i_clk,      // System clock, 50 MHz
  input  wire logic                   i_nrst,     // Async reset, active low
  input  wire spwm_pkg::spwm_bus_type i_bus,      // Register request
  input  wire logic                   i_adc_irq,  // ADC interrupt request
  output logic [7:0]                  o_rdata,    // Read data, next cycle
  output logic                        o_modulated_output, // PWM pin
  output logic                        o_shared_external_irq_line // Irq
);
  import spwm_pkg::*;

  spwm_ctl_type ctl_r;
  logic [15:0]  period_stage_r;   // Committed by high-byte write
  logic [15:0]  duty_stage_r;
  logic [7:0]   period_low_buf_r;
  logic [15:0]  duty_buf_r;
  logic [15:0]  period_act_r;
  logic [15:0]  duty_act_r;
  logic [15:0]  period_counter_r;
  logic [2:0]   presc_r;
  logic         out_r;
  logic         tick;
  logic         reload;
  logic         wr_ctl;
  logic         wr_perh;

  assign wr_ctl  = i_bus.wr && (i_bus.addr == ADDR_CONTROL);
  assign wr_perh = i_bus.wr && (i_bus.addr == ADDR_PERIOD_HIGH);
  assign tick    = ctl_r.module_enable &&
                   (presc_r == ctl_r.clock_prescale_field);        // [RL1]
  assign reload  = tick && (period_counter_r == period_act_r);     // [RL2]

  // Control fields; flag set beats a same-cycle clear
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctl_r <= spwm_ctl_type'(REG_RESET);                          // [RL14]
    end else begin
      if (wr_ctl) begin
        ctl_r.module_enable        <= i_bus.wdata[7];
        ctl_r.clock_prescale_field <= i_bus.wdata[6:4];
        ctl_r.idle_level           <= i_bus.wdata[3];
        ctl_r.reload_irq_enable    <= i_bus.wdata[2];
        ctl_r.output_polarity      <= i_bus.wdata[1];
      end
      if (reload) begin
        ctl_r.reload_irq_flag <= 1'b1;                             // [RL6]
      end else if (wr_ctl && i_bus.wdata[0]) begin
        ctl_r.reload_irq_flag <= 1'b0;                             // [RL8]
      end
    end
  end

  // Byte buffers, committed as a set by the period high byte
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      period_low_buf_r <= REG_RESET;                               // [RL14]
      duty_buf_r       <= WORD_RESET;
      period_stage_r   <= WORD_RESET;
      duty_stage_r     <= WORD_RESET;
    end else begin
      if (i_bus.wr && i_bus.addr == ADDR_PERIOD_LOW) begin
        period_low_buf_r <= i_bus.wdata;                           // [RL12]
      end
      if (i_bus.wr && i_bus.addr == ADDR_DUTY_HIGH) begin
        duty_buf_r[15:8] <= i_bus.wdata;                           // [RL12]
      end
      if (i_bus.wr && i_bus.addr == ADDR_DUTY_LOW) begin
        duty_buf_r[7:0] <= i_bus.wdata;                            // [RL12]
      end
      if (wr_perh) begin
        period_stage_r <= {i_bus.wdata, period_low_buf_r};         // [RL13]
        duty_stage_r   <= duty_buf_r;                              // [RL13]
      end
    end
  end

  // Active compare values only move at reload or while stopped,
  // so a half-written update can never shape a pulse
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      period_act_r <= WORD_RESET;
      duty_act_r   <= WORD_RESET;
    end else if (reload || !ctl_r.module_enable) begin
      period_act_r <= period_stage_r;                              // [RL16]
      duty_act_r   <= duty_stage_r;                                // [RL5]
    end
  end

  // Prescaler and counter
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      presc_r          <= PS_RESET;
      period_counter_r <= WORD_RESET;
    end else if (!ctl_r.module_enable) begin
      presc_r          <= PS_RESET;                                // [RL15]
      period_counter_r <= WORD_RESET;                              // [RL15]
    end else if (tick) begin
      presc_r <= PS_RESET;                                         // [RL1]
      if (reload) begin
        period_counter_r <= WORD_RESET;                            // [RL2]
      end else begin
        period_counter_r <= period_counter_r + 16'h0001;           // [RL1]
      end
    end else begin
      presc_r <= presc_r + 3'h1;                                   // [RL1]
    end
  end

  // Registered output pin
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_r <= 1'b0;
    end else if (!ctl_r.module_enable) begin
      out_r <= ctl_r.idle_level;                                   // [RL10]
    end else begin
      out_r <= (period_counter_r >= duty_act_r)                    // [RL3]
               ^ ctl_r.output_polarity;                            // [RL4]
    end
  end

  // Read port: data valid the cycle after the strobe, else zero
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= REG_RESET;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_CONTROL:     o_rdata <= ctl_r;
        ADDR_PERIOD_HIGH: o_rdata <= period_stage_r[15:8];         // [RL11]
        ADDR_PERIOD_LOW:  o_rdata <= period_low_buf_r;             // [RL11]
        ADDR_DUTY_HIGH:   o_rdata <= duty_buf_r[15:8];             // [RL11]
        ADDR_DUTY_LOW:    o_rdata <= duty_buf_r[7:0];              // [RL11]
        default:          o_rdata <= REG_RESET;
      endcase
    end else begin
      o_rdata <= REG_RESET;
    end
  end

  assign o_modulated_output = out_r;
  assign o_shared_external_irq_line =
    (ctl_r.reload_irq_flag && ctl_r.reload_irq_enable)             // [RL7]
    || i_adc_irq;                                                  // [RL9]
endmodule

// >>> logic/spwm_pkg.sv
// Summary of operation
// RL1 - A 16-bit counter advances once every prescale+1 clocks via a 3-bit prescaler.
// RL2 - When the counter equals the period it reloads to zero.
// RL3 - With polarity clear the output is low below the duty and high at or above it.
// RL4 - With polarity set the modulated output is inverted.
// RL5 - Duty is double-buffered and takes effect only at a reload or while disabled.
// RL6 - Every reload to zero sets the interrupt flag.
// RL7 - The interrupt reaches the processor only while its enable is set.
// RL8 - Writing one to the flag bit clears it.
// RL9 - The flag drives the external interrupt line shared with the ADC.
// RL10 - While disabled the output shows the idle-level bit.
// RL11 - Period and duty are split into high and low byte registers.
// RL12 - Duty bytes and the period low byte are held in temporary buffers.
// RL13 - A period high byte write commits the buffered values; write it last.
// RL14 - All five registers reset to zero.
// RL15 - While disabled the counter and prescaler are held at zero.
// RL16 - Committed values reach the comparisons at the next reload.
package spwm_pkg;
  localparam logic [15:0] ADDR_CONTROL     = 16'ha028;
  localparam logic [15:0] ADDR_PERIOD_HIGH = 16'ha029;
  localparam logic [15:0] ADDR_PERIOD_LOW  = 16'ha02a;
  localparam logic [15:0] ADDR_DUTY_HIGH   = 16'ha02b;
  localparam logic [15:0] ADDR_DUTY_LOW    = 16'ha02c;
  localparam logic [7:0]  REG_RESET        = 8'h00;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [2:0]  PS_RESET         = 3'h0;

  typedef struct packed {
    logic       module_enable;
    logic [2:0] clock_prescale_field;
    logic       idle_level;
    logic       reload_irq_enable;
    logic       output_polarity;
    logic       reload_irq_flag;
  } spwm_ctl_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } spwm_bus_type;
endpackage

// >>> dv/spwm_top_monitor.sv
module spwm_top_monitor
  import spwm_pkg::*;
(
  input wire logic                   i_clk,   // Clock
  input wire logic                   i_nrst,  // Reset
  input wire spwm_pkg::spwm_bus_type i_bus,   // Bus
  input wire logic                   i_adc_irq,  // ADC
  input wire logic [7:0]             o_rdata,    // Data
  input wire logic                   o_modulated_output, // Pin
  input wire logic                   o_shared_external_irq_line // Irq
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  wire logic cw  = i_bus.wr && i_bus.addr == ADDR_CONTROL;
  wire logic irq = o_shared_external_irq_line;
  property rb(a);
    i_bus.wr && i_bus.addr == a ##1 i_bus.rd && i_bus.addr == a
      |=> o_rdata == $past(i_bus.wdata, 2);
  endproperty
  AST_ADC: assert property (i_adc_irq |-> irq)
    else $error("adc not on irq");
  AST_UNMAP: assert property (i_bus.rd && i_bus.addr > ADDR_DUTY_LOW
    |=> o_rdata == 8'h00) else $error("unmapped read");
  AST_QUIET: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("stray data");
  AST_DUTY: assert property (rb(ADDR_DUTY_LOW))
    else $error("duty buffer");
  AST_PER: assert property (rb(ADDR_PERIOD_HIGH))
    else $error("period high");
  AST_IDLE: assert property (cw && !i_bus.wdata[7] ##1 !cw
    |=> o_modulated_output == $past(i_bus.wdata[3], 2)) else $error("idle");
  AST_MASK: assert property (cw && !i_bus.wdata[2]
    |=> irq == i_adc_irq) else $error("mask");
  // Second write lands while disabled, so no reload can win
  AST_CLR: assert property (cw && !i_bus.wdata[7] ##1
    cw && i_bus.wdata[0] |=> irq == i_adc_irq) else $error("clear");
  cover property (cw && i_bus.wdata[7]);
  cover property ($rose(irq) && !i_adc_irq);
  cover property ($rose(o_modulated_output));
endmodule
bind spwm_top spwm_top_monitor u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_bus(i_bus), .i_adc_irq(i_adc_irq), .o_rdata(o_rdata),
  .o_modulated_output(o_modulated_output),
  .o_shared_external_irq_line(o_shared_external_irq_line));

// >>> dv/spwm_top_tb.sv
module spwm_top_tb import spwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic         i_clk = 0, i_nrst = 0, i_adc_irq = 0, e_out = 0;
  logic         o_mod, o_irq, tk, rl, fl, ok;
  logic [7:0]   o_rdata, c, e_rd = 0, rg [5] = '{default: 0};
  logic [15:0]  cnt = 0, pa = 0, da = 0, sp = 0, sd = 0;
  spwm_bus_type i_bus = '0;
  int           pre = 0, ix, per, fails = 0, samples_checked = 0;
  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, x);
    samples_checked++;
    if (g !== x) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Whole request set once per edge, so strobes never get two drivers
  task automatic bus(logic w, r, logic [15:0] a, logic [7:0] d);
    i_bus <= '{w, r, a, d};
    @(posedge i_clk);
  endtask
  task automatic pause(int n);
    i_bus <= '0;
    i_adc_irq <= $urandom % 4 == 0;
    repeat (n) @(posedge i_clk);
  endtask
  spwm_top u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(i_bus),
    .i_adc_irq(i_adc_irq), .o_rdata(o_rdata), .o_modulated_output(o_mod),
    .o_shared_external_irq_line(o_irq));
  initial begin
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    #(20 * 30000);
    fails++;
    conclude();
  end
  always @(posedge i_clk) begin
    if (i_nrst) begin
      chk(o_mod, e_out);
      chk(o_rdata, e_rd);
      chk(o_irq, rg[0][0] & rg[0][2] | i_adc_irq);
      ok = i_bus.addr inside {[ADDR_CONTROL:ADDR_DUTY_LOW]};
      ix = i_bus.addr[2:0];
      e_out = rg[0][7] ? (cnt >= da) ^ rg[0][1] : rg[0][3];
      e_rd = i_bus.rd && ok ? rg[ix] : 8'h00;
      tk = rg[0][7] && pre == rg[0][6:4];
      rl = tk && cnt == pa;
      if (!rg[0][7] || rl)
        {pa, da} = {sp, sd};
      cnt = !rg[0][7] || rl ? 16'h0 : cnt + 16'(tk);
      pre = !rg[0][7] || tk ? 0 : pre + 1;
      fl = rl | rg[0][0] & !(i_bus.wr && ok && ix == 0 && i_bus.wdata[0]);
      if (i_bus.wr && ok && ix == 1)
        {sp, sd} = {i_bus.wdata, rg[2], rg[3], rg[4]};
      if (i_bus.wr && ok)
        rg[ix] = i_bus.wdata;
      rg[0][0] = fl;
    end
  end
  initial begin
    void'($urandom(32'h886d));
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      per = $urandom % 24;
      c = {1'b1, 3'(k), 2'($urandom), 1'(k), 1'b1};
      for (int a = 'ha027; a < 'ha02e; a++)
        bus(0, 1, 16'(a), 0);
      bus(1, 0, ADDR_PERIOD_LOW, 8'(per));
      bus(1, 0, ADDR_DUTY_HIGH, 8'(k / 7));
      bus(1, 0, ADDR_DUTY_LOW, 8'($urandom % (per + 3)));
      bus(0, 1, ADDR_DUTY_LOW, 0);
      for (int j = 0; j < 3; j++) begin
        bus(1, 0, ADDR_PERIOD_HIGH, 0);
        bus(0, 1, ADDR_PERIOD_HIGH, 0);
        bus(1, 0, ADDR_CONTROL, c);
        pause((per + 1) * (k + 1) * 2);
        bus(1, 0, ADDR_DUTY_LOW, 8'($urandom % (per + 2)));
        pause((per + 1) * (k + 1) * 2);
      end
      bus(1, 0, ADDR_CONTROL, {1'b0, 3'(k), 4'($urandom)});
      bus(1, 0, ADDR_CONTROL, 8'h05);
      pause(3);
    end
    conclude();
  end
endmodule
